/* logic/pcc_axis_counters.sv */
/*
 * position counter pair with capture registers for one axis, reached
 * over an axi4-lite slave. holds the configuration, the command port,
 * both counters, both capture registers and the ring limit.
 * assumes step, direction and origin inputs are clk-domain pulses and
 * the capture pin is asynchronous and active low.
 */
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
// Functional notes
// (R1) config bit 0 picks counter one source
// (R2) config bit 1 picks counter two source
// (R3) config bit 2 holds counter one
// (R4) config bit 3 holds counter two
// (R5) config bit 4 clears counter one on capture
// (R6) config bit 8 clears counter two on capture
// (R7) config bit 5 disables capture from pin
// (R8) command 29h always captures counter one
// (R9) pin capture fires once per edge
// (R10) config bit 6 captures at origin return
// (R11) config bit 7 makes counter one a ring
// (R12) capture keeps old value, counter restarts zero
`timescale 1ns/1ns
`default_nettype none
module pcc_axis_counters
	import pcc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// count sources from the pulse generator and encoder decoder
	input wire logic cmd_step,
	input wire logic cmd_dir_up,
	input wire logic enc_step,
	input wire logic enc_dir_up,
	// origin return capture moment
	input wire logic origin_event,
	// asynchronous capture pin, active low
	input wire logic external_capture_pin_n,
	// state seen by the rest of the axis
	output logic [CTR_W-1:0] position_counter_one,
	output logic [CTR_W-1:0] position_counter_two,
	output logic [CTR_W-1:0] capture_register_one,
	output logic [CTR_W-1:0] capture_register_two,
	output logic ctr1_ring_active
);
	// configuration register
	logic [CFG_W-1:0] cfg;
	// ring limit for counter one
	logic [CTR_W-1:0] ring_limit;
	// held write address and data
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;

	// merge a write word into an old word under byte strobes
	function automatic logic [DATA_W-1:0] strb_merge
	(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [3:0] strb
	);
		logic [DATA_W-1:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = new_word[i*8 +: 8];
		return res;
	endfunction

	// true for any offset that holds a register
	function automatic logic addr_mapped
	(
		input logic [ADDR_W-1:0] a
	);
		return (a == OFS_CONFIG) || (a == OFS_COMMAND) ||
			(a == OFS_COUNTER1) || (a == OFS_COUNTER2) ||
			(a == OFS_CAPTURE1) || (a == OFS_CAPTURE2) ||
			(a == OFS_RING_LIMIT);
	endfunction

	// widen a counter value to a bus word
	function automatic logic [DATA_W-1:0] ctr_word
	(
		input logic [CTR_W-1:0] v
	);
		return {{(DATA_W-CTR_W){1'b0}}, v};
	endfunction

	// write side decode: both halves held and no answer pending
	wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_ok = wr_go && addr_mapped(wr_addr);
	wire wr_cfg = wr_go && (wr_addr == OFS_CONFIG);
	wire wr_cmd = wr_go && (wr_addr == OFS_COMMAND);
	wire wr_ctr1 = wr_go && (wr_addr == OFS_COUNTER1);
	wire wr_ctr2 = wr_go && (wr_addr == OFS_COUNTER2);
	wire wr_ring = wr_go && (wr_addr == OFS_RING_LIMIT);

	// merged words for registers that software writes
	wire [DATA_W-1:0] cfg_merged =
		strb_merge(DATA_W'(cfg), wr_data, wr_strb);
	wire [DATA_W-1:0] ring_merged =
		strb_merge(ctr_word(ring_limit), wr_data, wr_strb);
	wire [DATA_W-1:0] ctr1_merged =
		strb_merge(ctr_word(position_counter_one), wr_data, wr_strb);
	wire [DATA_W-1:0] ctr2_merged =
		strb_merge(ctr_word(position_counter_two), wr_data, wr_strb);

	// (R8) command capture, pin setting ignored
	wire cmd_capture = wr_cmd && wr_strb[0] &&
		(wr_data[7:0] == CMD_CAPTURE);

	// synchronised falling edge of the capture pin
	logic pin_fall;

	// (R9) edge detect yields one pulse per edge
	pcc_pin_edge u_pin_edge
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_n(external_capture_pin_n),
		.fall_pulse(pin_fall)
	);

	// (R7) pin capture gated by disable bit
	wire pin_capture = pin_fall & ~cfg[BIT_CTR1_PIN_LATCH_DISABLE];
	// (R10) origin return capture when enabled
	wire origin_capture = origin_event &
		cfg[BIT_CTR1_ORIGIN_LATCH_ENABLE];
	// any of the three sources captures both counters together
	wire capture_any = pin_capture | cmd_capture | origin_capture;

	// (R1) counter one: 0 command, 1 encoder
	wire c1_step = cfg[BIT_CTR1_SOURCE_SELECT] ? enc_step : cmd_step;
	wire c1_up = cfg[BIT_CTR1_SOURCE_SELECT] ? enc_dir_up : cmd_dir_up;
	// (R2) counter two: 0 encoder, 1 command
	wire c2_step = cfg[BIT_CTR2_SOURCE_SELECT] ? cmd_step : enc_step;
	wire c2_up = cfg[BIT_CTR2_SOURCE_SELECT] ? cmd_dir_up : enc_dir_up;

	// (R5) clear counter one with its capture
	wire c1_clear = capture_any & cfg[BIT_CTR1_CLEAR_ON_LATCH];
	// (R6) clear counter two with its capture
	wire c2_clear = capture_any & cfg[BIT_CTR2_CLEAR_ON_LATCH];

	// counter one; a software load in the same edge wins
	pcc_counter u_ctr1
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.step(c1_step),
		.step_up(c1_up),
		// (R3) hold counter one when set
		.inhibit(cfg[BIT_CTR1_COUNT_INHIBIT]),
		.clear(c1_clear),
		.load(wr_ctr1),
		.load_value(ctr1_merged[CTR_W-1:0]),
		// (R11) ring wrap against the limit
		.ring_en(cfg[BIT_CTR1_RING_MODE]),
		.ring_limit(ring_limit),
		.value(position_counter_one)
	);

	// counter two has no ring wrap, its ring mode is tied off
	pcc_counter u_ctr2
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.step(c2_step),
		.step_up(c2_up),
		// (R4) hold counter two when set
		.inhibit(cfg[BIT_CTR2_COUNT_INHIBIT]),
		.clear(c2_clear),
		.load(wr_ctr2),
		.load_value(ctr2_merged[CTR_W-1:0]),
		.ring_en(1'b0),
		.ring_limit(RST_RING_LIMIT),
		.value(position_counter_two)
	);

	// capture registers take the value before any clear
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			capture_register_one <= RST_COUNTER;
			capture_register_two <= RST_COUNTER;
		end
		// (R12) old value captured, counter restarts when its clear bit is set
		else if (capture_any)
		begin
			capture_register_one <= position_counter_one;
			capture_register_two <= position_counter_two;
		end
	end

	// configuration and ring limit, honouring byte strobes
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg <= RST_CONFIG;
			ring_limit <= RST_RING_LIMIT;
			ctr1_ring_active <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
				cfg <= cfg_merged[CFG_W-1:0];
			if (wr_ring)
				ring_limit <= ring_merged[CTR_W-1:0];
			// mirrors the ring bit one edge after it changes
			ctr1_ring_active <= cfg[BIT_CTR1_RING_MODE];
		end
	end

	// write channels: take address and data in either order, hold
	// both until the answer is taken, so only one write is in flight
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 4'h0;
		end
		else
		begin
			// address taken, then closed until the answer
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			// data taken, then closed until the answer
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// answer the cycle after both halves are held
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			// answer taken, reopen both channels
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read mux; the command word reads as zero
	wire [DATA_W-1:0] rd_word =
		(s_axi_araddr == OFS_CONFIG) ? DATA_W'(cfg) :
		(s_axi_araddr == OFS_COUNTER1) ? ctr_word(position_counter_one) :
		(s_axi_araddr == OFS_COUNTER2) ? ctr_word(position_counter_two) :
		(s_axi_araddr == OFS_CAPTURE1) ? ctr_word(capture_register_one) :
		(s_axi_araddr == OFS_CAPTURE2) ? ctr_word(capture_register_two) :
		(s_axi_araddr == OFS_RING_LIMIT) ? ctr_word(ring_limit) :
		'0;
	wire rd_ok = addr_mapped(s_axi_araddr);

	// read channel: one read in flight, data registered at the edge that takes the address
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* logic/pcc_counter.sv */
/*
 * one up/down position counter with hold, clear, load and ring wrap.
 * assumes step and direction come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module pcc_counter
	import pcc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic step,
	input wire logic step_up,
	input wire logic inhibit,
	input wire logic clear,
	input wire logic load,
	input wire logic [CTR_W-1:0] load_value,
	input wire logic ring_en,
	input wire logic [CTR_W-1:0] ring_limit,
	output logic [CTR_W-1:0] value
);
	logic [CTR_W-1:0] next_value; // value for the coming edge
	logic at_top; // counter sits at the ring limit
	logic at_zero; // counter sits at zero

	assign at_top = (value == ring_limit);
	assign at_zero = (value == RST_COUNTER);

	// a load from software beats a clear, a clear beats a step
	always_comb
	begin
		next_value = value;
		if (load)
			next_value = load_value;
		else if (clear)
			next_value = RST_COUNTER;
		else if (step && !inhibit)
		begin
			// ring mode wraps between zero and the limit
			if (step_up)
				next_value = (ring_en && at_top) ? RST_COUNTER
					: value + 1'b1;
			else
				next_value = (ring_en && at_zero) ? ring_limit
					: value - 1'b1;
		end
	end

	// counter register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			value <= RST_COUNTER;
		else
			value <= next_value;
	end
endmodule
`default_nettype wire

/* logic/pcc_pin_edge.sv */
/*
 * synchroniser and edge detector for the active-low capture pin.
 * assumes the pin is asynchronous to clk and idles high.
 */
`timescale 1ns/1ns
`default_nettype none
module pcc_pin_edge
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin_n,
	output logic fall_pulse
);
	// two-stage synchroniser, then one history stage
	logic sync_a;
	logic sync_b;
	logic hist;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			hist <= 1'b1;
			fall_pulse <= 1'b0;
		end
		else
		begin
			sync_a <= pin_n;
			sync_b <= sync_a;
			hist <= sync_b;
			// one pulse per high-to-low edge, not while held low
			fall_pulse <= hist & ~sync_b;
		end
	end
endmodule
`default_nettype wire

/* logic/pcc_pkg.sv */
/*
 * shared constants for the position counter and capture block:
 * register byte offsets, configuration bit positions, reset values,
 * the capture command code and the bus answer codes.
 * assumes a 32-bit axi4-lite register bus with byte addressing.
 */
package pcc_pkg;

	// counter and capture width
	localparam int CTR_W = 28;
	// bus address and data widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// configuration register width
	localparam int CFG_W = 9;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNTER1 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COUNTER2 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CAPTURE1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CAPTURE2 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RING_LIMIT = 8'h18;

	// configuration bit positions
	localparam int BIT_CTR1_SOURCE_SELECT = 0;
	localparam int BIT_CTR2_SOURCE_SELECT = 1;
	localparam int BIT_CTR1_COUNT_INHIBIT = 2;
	localparam int BIT_CTR2_COUNT_INHIBIT = 3;
	localparam int BIT_CTR1_CLEAR_ON_LATCH = 4;
	localparam int BIT_CTR1_PIN_LATCH_DISABLE = 5;
	localparam int BIT_CTR1_ORIGIN_LATCH_ENABLE = 6;
	localparam int BIT_CTR1_RING_MODE = 7;
	localparam int BIT_CTR2_CLEAR_ON_LATCH = 8;

	// reset values
	localparam logic [CFG_W-1:0] RST_CONFIG = 9'h000;
	localparam logic [CTR_W-1:0] RST_COUNTER = 28'h0000000;
	localparam logic [CTR_W-1:0] RST_RING_LIMIT = 28'hFFFFFFF;

	// command code that captures both counters
	localparam logic [7:0] CMD_CAPTURE = 8'h29;

	// axi answer codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* verif/pcc_axis_counters_properties.sv */
/*
 * concurrent checks on the axis counter block, seen from its ports.
 * assumes the bus master offers write address and data together.
 */
`timescale 1ns/1ns
`default_nettype none
module pcc_axis_counters_checker
	import pcc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic cmd_step,
	input wire logic cmd_dir_up,
	input wire logic enc_step,
	input wire logic enc_dir_up,
	input wire logic origin_event,
	input wire logic external_capture_pin_n,
	input wire logic [CTR_W-1:0] position_counter_one,
	input wire logic [CTR_W-1:0] position_counter_two,
	input wire logic [CTR_W-1:0] capture_register_one,
	input wire logic [CTR_W-1:0] capture_register_two,
	input wire logic ctr1_ring_active
);
	// mirror of the configuration word
	logic [CFG_W-1:0] cfg_m;
	// data of the write being committed
	logic [CFG_W-1:0] cfg_w;
	// a write commits at the next edge
	logic pend_any;
	logic pend_cfg;
	logic pend_cmd;
	// address and data both taken at this edge
	wire take_w = s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready;

	// commit one edge after the take, as the block does
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_m <= '0;
			cfg_w <= '0;
			pend_any <= 1'b0;
			pend_cfg <= 1'b0;
			pend_cmd <= 1'b0;
		end
		else
		begin
			pend_any <= take_w;
			pend_cfg <= take_w && s_axi_awaddr == OFS_CONFIG;
			pend_cmd <= take_w && s_axi_awaddr == OFS_COMMAND &&
				s_axi_wdata[7:0] == CMD_CAPTURE;
			cfg_w <= s_axi_wdata[CFG_W-1:0];
			if (pend_cfg)
				cfg_m <= cfg_w;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	AST_RING: assert property (
		ctr1_ring_active == $past(cfg_m[7]))
		else $error("ring flag does not follow config");
	AST_CMD_CAP: assert property (pend_cmd |=>
		capture_register_one == $past(position_counter_one) &&
		capture_register_two == $past(position_counter_two))
		else $error("command capture wrong");
	AST_CLR1: assert property (
		pend_cmd && cfg_m[4] |=> position_counter_one == '0)
		else $error("counter one not cleared");
	AST_CLR2: assert property (
		pend_cmd && cfg_m[8] |=> position_counter_two == '0)
		else $error("counter two not cleared");
	AST_ORIGIN: assert property (origin_event && cfg_m[6] |=>
		capture_register_one == $past(position_counter_one))
		else $error("origin capture wrong");
	AST_INH1: assert property (
		cfg_m[2] && !cfg_m[4] && !pend_any |=>
		$stable(position_counter_one))
		else $error("counter one moved while held");
	AST_INH2: assert property (
		cfg_m[3] && !cfg_m[8] && !pend_any |=>
		$stable(position_counter_two))
		else $error("counter two moved while held");
	AST_SRC1: assert property (
		!cfg_m[2] && !cfg_m[4] && !cfg_m[7] && !pend_any &&
		(cfg_m[0] ? enc_step && enc_dir_up : cmd_step && cmd_dir_up)
		|=> position_counter_one == $past(position_counter_one) +
		28'h0000001)
		else $error("counter one source wrong");
	AST_SRC2: assert property (
		!cfg_m[3] && !cfg_m[8] && !pend_any &&
		(cfg_m[1] ? cmd_step && !cmd_dir_up : enc_step && !enc_dir_up)
		|=> position_counter_two == $past(position_counter_two) -
		28'h0000001)
		else $error("counter two source wrong");
	AST_PIN: assert property (
		!cfg_m[5] && $fell(external_capture_pin_n) |-> ##4
		capture_register_one == $past(position_counter_one))
		else $error("pin capture wrong");
endmodule

bind pcc_axis_counters pcc_axis_counters_checker
	u_pcc_axis_counters_checker (.clk(clk), .sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
	.cmd_step(cmd_step), .cmd_dir_up(cmd_dir_up), .enc_step(enc_step),
	.enc_dir_up(enc_dir_up), .origin_event(origin_event),
	.external_capture_pin_n(external_capture_pin_n),
	.position_counter_one(position_counter_one),
	.position_counter_two(position_counter_two),
	.capture_register_one(capture_register_one),
	.capture_register_two(capture_register_two),
	.ctr1_ring_active(ctr1_ring_active));
`default_nettype wire

/* verif/tb_pcc_axis_counters.sv */
/*
 * self-checking bench for the axis counter block.
 * assumes the checker is bound from its own file.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_pcc_axis_counters
	import pcc_pkg::*;
;
	logic clk, sys_rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic cs, cu, es, eu, org, pin_n, ring;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] bres, rres;
	logic [3:0] wst;
	// design outputs, then expected counters and captures
	logic [CTR_W-1:0] p1, p2, c1, c2, e1, e2, k1, k2;
	logic [8:0] cfg;
	// ring limit that software last wrote
	logic [CTR_W-1:0] lim;
	int bad_count, n_tests, cyc;

	pcc_axis_counters u_pcc_axis_counters (.clk(clk), .sys_rst(sys_rst),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(wst), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bres), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rd), .s_axi_rresp(rres), .cmd_step(cs),
		.cmd_dir_up(cu), .enc_step(es), .enc_dir_up(eu),
		.origin_event(org), .external_capture_pin_n(pin_n),
		.position_counter_one(p1), .position_counter_two(p2),
		.capture_register_one(c1), .capture_register_two(c2),
		.ctr1_ring_active(ring));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// next count of counter one; in ring mode it wraps between zero
	// and the limit in both directions
	function automatic logic [CTR_W-1:0] next_one
	(
		input logic [CTR_W-1:0] v,
		input logic up
	);
		if (cfg[7] && up && v == lim)
			return '0;
		if (cfg[7] && !up && v == '0)
			return lim;
		return up ? v + 1'b1 : v - 1'b1;
	endfunction

	// reference counters follow the chosen sources and holds
	always @(posedge clk)
	begin
		if (!sys_rst && !cfg[2] && (cfg[0] ? es : cs))
			e1 <= next_one(e1, cfg[0] ? eu : cu);
		if (!sys_rst && !cfg[3] && (cfg[1] ? cs : es))
			e2 <= (cfg[1] ? cu : eu) ? e2 + 1'b1 : e2 - 1'b1;
	end

	// cuts a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_tests++;
		if (got !== ex)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// write: offer both channels, drop each once taken, then the answer
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ah, wh, h;
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		do
		begin
			@(negedge clk);
			ah = awv && awr;
			wh = wv && wr;
			@(posedge clk);
			if (ah)
				awv <= 1'b0;
			if (wh)
				wv <= 1'b0;
		end while (awv || wv);
		br <= 1'b1;
		do
		begin
			@(negedge clk);
			h = bv;
			r = bres;
			@(posedge clk);
		end while (!h);
		br <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic h;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		do
		begin
			@(negedge clk);
			h = arr;
			@(posedge clk);
		end while (!h);
		arv <= 1'b0;
		rr <= 1'b1;
		do
		begin
			@(negedge clk);
			h = rv;
			d = rd;
			r = rres;
			@(posedge clk);
		end while (!h);
		rr <= 1'b0;
	endtask

	// random steps on both sources, then quiet
	task automatic run(input int n);
		repeat (n)
		begin
			@(posedge clk);
			{cs, cu, es, eu} <= 4'($urandom);
		end
		@(posedge clk);
		{cs, cu, es, eu} <= 4'h0;
		repeat (2) @(posedge clk);
	endtask

	// a hit captures the old counts and may clear them
	task automatic cap_check(input logic hit);
		@(negedge clk);
		if (hit)
		begin
			k1 = e1;
			k2 = e2;
			if (cfg[4])
				e1 = '0;
			if (cfg[8])
				e2 = '0;
		end
		chk("capture1", k1, c1);
		chk("capture2", k2, c2);
		chk("counter1", e1, p1);
		chk("counter2", e2, p2);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		{awv, wv, br, arv, rr, cs, cu, es, eu, org} = '0;
		{awa, ara, wd} = '0;
		{e1, e2, k1, k2, cfg} = '0;
		lim = RST_RING_LIMIT;
		{bad_count, n_tests, cyc} = '0;
		wst = 4'hF;
		pin_n = 1'b1;
		sys_rst = 1'b1;
		void'($urandom(55775));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		axr(OFS_CONFIG, d, r);
		chk("config", 32'h0, d);
		// the command word never reads back what was written
		axr(OFS_COMMAND, d, r);
		chk("command", 32'h0, d);
		chk("rresp_ok", RESP_OKAY, r);
		axr(OFS_RING_LIMIT, d, r);
		chk("ring_limit", 32'h0FFFFFFF, d);
		axr(8'h1C, d, r);
		chk("rresp", RESP_SLVERR, r);
		axw(8'h1C, 32'hFFFFFFFF, r);
		chk("bresp", RESP_SLVERR, r);
		$display("test reset done");
		for (int i = 0; i < 12; i++)
		begin
			cfg = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom);
			axw(OFS_CONFIG, {23'h0, cfg}, r);
			@(negedge clk);
			chk("ring", {31'h0, cfg[7]}, {31'h0, ring});
			// small ring limit so that random steps reach the wrap
			lim = {20'h0, 8'($urandom) | 8'h10};
			axw(OFS_RING_LIMIT, {4'h0, lim}, r);
			chk("bresp_ok", RESP_OKAY, r);
			axr(OFS_RING_LIMIT, d, r);
			chk("ring_limit", {4'h0, lim}, d);
			// counter one restarts inside the ring
			e1 = '0;
			axw(OFS_COUNTER1, 32'h0, r);
			// counter two takes only its two low bytes
			d = $urandom;
			e2 = {e2[27:16], d[15:0]};
			wst <= 4'h3;
			axw(OFS_COUNTER2, d, r);
			wst <= 4'hF;
			run(20);
			cap_check(1'b0);
			axw(OFS_COMMAND, 32'h28, r);
			cap_check(1'b0);
			axw(OFS_COMMAND, 32'h29, r);
			cap_check(1'b1);
			// captured and live values as software reads them
			axr(OFS_CAPTURE1, d, r);
			chk("capture1_read", {4'h0, k1}, d);
			axr(OFS_COUNTER2, d, r);
			chk("counter2_read", {4'h0, e2}, d);
			chk("rresp_ok", RESP_OKAY, r);
			run(10);
			@(posedge clk);
			org <= 1'b1;
			@(posedge clk);
			org <= 1'b0;
			cap_check(cfg[6]);
			run(10);
			@(posedge clk);
			pin_n <= 1'b0;
			repeat (6) @(posedge clk);
			cap_check(!cfg[5]);
			run(10);
			cap_check(1'b0);
			@(posedge clk);
			pin_n <= 1'b1;
			repeat (3) @(posedge clk);
			$display("test config %h done", cfg);
		end
		finish_test();
	end
endmodule
`default_nettype wire
